// *** rtl/mdp_top.sv ***
// four-engine dma port front end with ahb-lite register slave
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module mdp_top
   import mdp_pkg::*;
#(
   parameter logic [3:0] regbus_base_upper_bits = `MDP_BASE_DFLT,
   parameter logic [4:0] port0_addr_upper_bits = `MDP_UPPER_DFLT,
   parameter logic [4:0] port1_addr_upper_bits = `MDP_UPPER_DFLT,
   parameter bit tx_a_done_bit_check = 1'b1,
   parameter bit rx_a_done_bit_check = 1'b1,
   parameter bit tx_b_done_bit_check = 1'b1,
   parameter bit rx_b_done_bit_check = 1'b1,
   parameter bit tx_a_timeout_counter_present = 1'b1,
   parameter bit rx_a_timeout_counter_present = 1'b1,
   parameter bit tx_b_timeout_counter_present = 1'b1,
   parameter bit rx_b_timeout_counter_present = 1'b1,
   parameter logic [7:0] timeout_prescale = `MDP_PRESCALE_DFLT
)
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output var logic hreadyout,
   output var logic hresp,
   output var logic [31:0] hrdata,
   // interrupt
   output var logic dma_irq,
   // memory port address phase, index is the port
   output logic [1:0] port_addr_request,
   output logic [1:0][31:0] port_address,
   output logic [1:0] port_read_not_write,
   output logic [1:0][1:0] port_xfer_size,
   input wire logic [1:0] port_addr_accept,
   // memory port read data
   input wire logic [1:0] port_rd_ready,
   input wire logic [1:0][31:0] port_rd_data,
   // memory port write lanes
   output var logic [1:0][31:0] port_wr_data,
   output var logic [1:0] port_wr_push_rise,
   output var logic [1:0] port_wr_push_fall,
   output var logic [1:0][3:0] port_wr_byte_en_rise,
   output var logic [1:0][3:0] port_wr_byte_en_fall,
   input wire logic [1:0] port_wr_buf_full_rise,
   input wire logic [1:0] port_wr_buf_full_fall
);
   // engine order: tx_a, rx_a on port 0; tx_b, rx_b on port 1
   localparam logic [3:0] CHECK_EN = {rx_b_done_bit_check,
      tx_b_done_bit_check, rx_a_done_bit_check, tx_a_done_bit_check};
   localparam logic [3:0] TMO_EN = {rx_b_timeout_counter_present,
      tx_b_timeout_counter_present, rx_a_timeout_counter_present,
      tx_a_timeout_counter_present};
   localparam logic [1:0][4:0] PORT_UPPER = {port1_addr_upper_bits,
      port0_addr_upper_bits};

   mdp_top_state_t q;
   mdp_top_state_t n;
   logic [1:0] busy;

   ////////////////////////////////////////////////////////////////////
   // register read view

   function automatic logic [31:0] rd_word(input mdp_top_state_t s,
      input logic [7:0] a);
      logic [1:0] e;
      logic [31:0] r;
      e = a[5:4];
      r = '0;
      if (a[7:6] == 2'b00)
      begin
         unique case (a[3:2])
            `MDP_REG_CTRL:
            begin
               r[`MDP_CTRL_START] = (s.st[e] != E_IDLE);
               r[`MDP_CTRL_RNW] = s.rnw[e];
               r[`MDP_CTRL_SIZE] = s.size[e];
            end
            `MDP_REG_ADDR:
            begin
               r = s.addr[e];
            end
            `MDP_REG_TMO:
            begin
               r[`MDP_TMO_W-1:0] = s.tmo[e];
            end
            `MDP_REG_LAST:
            begin
               r = s.last[e];
            end
         endcase
      end
      else
      begin
         case (a)
            `MDP_OFF_IRQ_STAT:
            begin
               r[`MDP_IRQ_W-1:0] = s.stat;
            end
            `MDP_OFF_IRQ_MASK:
            begin
               r[`MDP_IRQ_W-1:0] = s.mask;
            end
            `MDP_OFF_WDATA0:
            begin
               r = s.wdat[0];
            end
            `MDP_OFF_WDATA1:
            begin
               r = s.wdat[1];
            end
            `MDP_OFF_WCTRL0:
            begin
               r[`MDP_WCTRL_BE] = s.wlane[0] ? s.be_fall[0] : s.be_rise[0];
               r[`MDP_WCTRL_LANE] = s.wlane[0];
               r[`MDP_WCTRL_PEND] = s.wpend[0];
            end
            `MDP_OFF_WCTRL1:
            begin
               r[`MDP_WCTRL_BE] = s.wlane[1] ? s.be_fall[1] : s.be_rise[1];
               r[`MDP_WCTRL_LANE] = s.wlane[1];
               r[`MDP_WCTRL_PEND] = s.wpend[1];
            end
            default:
            begin
               r = '0;
            end
         endcase
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      logic [`MDP_IRQ_W-1:0] ev;
      logic [`MDP_IRQ_W-1:0] clr;
      logic tick;
      logic [1:0] eb;
      logic [1:0] pw;
      logic found;
      logic sel;
      logic port_free;
      ev = '0;
      clr = '0;
      tick = 1'b0;
      eb = '0;
      pw = '0;
      found = 1'b0;
      sel = 1'b0;
      port_free = 1'b0;
      n = q;
      n.launch = '0;
      n.push_rise = '0;
      n.push_fall = '0;

      // shared prescaler, a setting of zero ticks every cycle
      tick = (timeout_prescale == 8'h00) ||
         (q.presc == timeout_prescale - 8'h01);
      n.presc = tick ? 8'h00 : q.presc + 8'h01;

      for (int e = 0; e < 4; e++)
      begin
         unique case (q.st[e])
            E_IDLE, E_PEND:
            begin
            end
            E_ACC:
            begin
               if (port_addr_accept[e / 2] && q.owner[e / 2] == e[0])
               begin
                  n.st[e] = q.rnw[e] ? E_DATA : E_DONE;
               end
            end
            E_DATA:
            begin
               if (port_rd_ready[e / 2] && q.owner[e / 2] == e[0])
               begin
                  n.last[e] = port_rd_data[e / 2];
                  if (CHECK_EN[e] && port_rd_data[e / 2][`MDP_DONE_BIT])
                  begin
                     ev[4 + e] = 1'b1;
                     n.st[e] = E_IDLE;
                  end
                  else
                  begin
                     n.st[e] = E_DONE;
                  end
               end
            end
            E_DONE:
            begin
               ev[e] = 1'b1;
               n.st[e] = E_IDLE;
            end
         endcase

         // counter logic folds away when the engine has none
         if (TMO_EN[e] && q.tmo[e] != '0)
         begin
            if (tick)
            begin
               if (q.tcnt[e] + 1'b1 == q.tmo[e])
               begin
                  ev[8 + e] = 1'b1;
                  n.tcnt[e] = '0;
               end
               else
               begin
                  n.tcnt[e] = q.tcnt[e] + 1'b1;
               end
            end
         end
         else
         begin
            n.tcnt[e] = '0;
         end
      end

      // port arbiter: tx beats rx; one engine owns a port until it ends
      for (int p = 0; p < 2; p++)
      begin
         port_free = !q.launch[p] && !busy[p];
         for (int k = 0; k < 2; k++)
         begin
            if (q.st[2 * p + k] == E_ACC || q.st[2 * p + k] == E_DATA)
            begin
               port_free = 1'b0;
            end
         end
         found = 1'b0;
         sel = 1'b0;
         if (q.st[2 * p] == E_PEND)
         begin
            found = 1'b1;
         end
         else if (q.st[2 * p + 1] == E_PEND)
         begin
            found = 1'b1;
            sel = 1'b1;
         end
         if (port_free && found)
         begin
            eb = 2'(2 * p + int'(sel));
            n.launch[p] = 1'b1;
            n.owner[p] = sel;
            n.laddr[p] = {PORT_UPPER[p],
               q.addr[eb][`MDP_LOW_ADDR_W-1:0]};
            n.lrnw[p] = q.rnw[eb];
            n.lsize[p] = q.size[eb];
            n.st[eb] = E_ACC;
         end

         // push waits out a full lane rather than dropping the word
         if (q.wpend[p])
         begin
            if (!q.wlane[p] && !port_wr_buf_full_rise[p])
            begin
               n.push_rise[p] = 1'b1;
               n.wpend[p] = 1'b0;
            end
            else if (q.wlane[p] && !port_wr_buf_full_fall[p])
            begin
               n.push_fall[p] = 1'b1;
               n.wpend[p] = 1'b0;
            end
         end
      end

      // bus: address phase, then one wait cycle, then the answer
      if (q.ap_valid)
      begin
         n.ap_valid = 1'b0;
         n.hready = 1'b1;
         if (!q.ap_write)
         begin
            n.hrdata = q.ap_hit ? rd_word(q, q.ap_addr) : '0;
         end
         else if (q.ap_hit && q.ap_addr[7:6] == 2'b00)
         begin
            eb = q.ap_addr[5:4];
            unique case (q.ap_addr[3:2])
               `MDP_REG_CTRL:
               begin
                  if (hwdata[`MDP_CTRL_START] && q.st[eb] == E_IDLE)
                  begin
                     n.rnw[eb] = hwdata[`MDP_CTRL_RNW];
                     n.size[eb] = mdp_size_t'(hwdata[`MDP_CTRL_SIZE]);
                     n.st[eb] = E_PEND;
                  end
               end
               `MDP_REG_ADDR:
               begin
                  n.addr[eb] = hwdata;
               end
               `MDP_REG_TMO:
               begin
                  n.tmo[eb] = hwdata[`MDP_TMO_W-1:0];
                  n.tcnt[eb] = '0;
               end
               `MDP_REG_LAST:
               begin
               end
            endcase
         end
         else if (q.ap_hit)
         begin
            pw[0] = (q.ap_addr == `MDP_OFF_WCTRL0);
            pw[1] = (q.ap_addr == `MDP_OFF_WCTRL1);
            case (q.ap_addr)
               `MDP_OFF_IRQ_STAT:
               begin
                  clr = hwdata[`MDP_IRQ_W-1:0];
               end
               `MDP_OFF_IRQ_MASK:
               begin
                  n.mask = hwdata[`MDP_IRQ_W-1:0];
               end
               `MDP_OFF_WDATA0:
               begin
                  n.wdat[0] = hwdata;
               end
               `MDP_OFF_WDATA1:
               begin
                  n.wdat[1] = hwdata;
               end
               default:
               begin
               end
            endcase
            for (int p = 0; p < 2; p++)
            begin
               if (pw[p])
               begin
                  // the idle lane keeps every byte disabled
                  n.wlane[p] = hwdata[`MDP_WCTRL_LANE];
                  n.be_rise[p] = hwdata[`MDP_WCTRL_LANE] ?
                     `MDP_BE_NONE : hwdata[`MDP_WCTRL_BE];
                  n.be_fall[p] = hwdata[`MDP_WCTRL_LANE] ?
                     hwdata[`MDP_WCTRL_BE] : `MDP_BE_NONE;
                  n.wpend[p] = 1'b1;
               end
            end
         end
      end
      else if (hsel && htrans[1] && hready && q.hready)
      begin
         n.ap_valid = 1'b1;
         n.ap_write = hwrite;
         n.ap_addr = haddr[7:0];
         n.ap_hit = (haddr[31:28] == regbus_base_upper_bits);
         n.hready = 1'b0;
      end

      // a fresh event outweighs a clear in the same cycle
      n.stat = (q.stat & ~clr) | ev;
      n.irq = |(n.stat & n.mask);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q <= '0;
         q.hready <= 1'b1;
         q.be_rise <= {2{`MDP_BE_NONE}};
         q.be_fall <= {2{`MDP_BE_NONE}};
      end
      else
      begin
         q <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // port request stages

   mdp_port_if pif [1:0] ();

   for (genvar p = 0; p < 2; p++)
   begin : g_port
      assign pif[p].launch = q.launch[p];
      assign pif[p].addr = q.laddr[p];
      assign pif[p].rnw = q.lrnw[p];
      assign pif[p].size = q.lsize[p];
      assign busy[p] = pif[p].busy;

      mdp_port_req u_req
      (
         .hclk(hclk),
         .hresetn(hresetn),
         .pif(pif[p]),
         .port_addr_request(port_addr_request[p]),
         .port_address(port_address[p]),
         .port_read_not_write(port_read_not_write[p]),
         .port_xfer_size(port_xfer_size[p]),
         .port_addr_accept(port_addr_accept[p])
      );
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   assign hreadyout = q.hready;
   assign hresp = 1'b0;
   assign hrdata = q.hrdata;
   assign dma_irq = q.irq;
   assign port_wr_data = q.wdat;
   assign port_wr_push_rise = q.push_rise;
   assign port_wr_push_fall = q.push_fall;
   assign port_wr_byte_en_rise = q.be_rise;
   assign port_wr_byte_en_fall = q.be_fall;
endmodule
`default_nettype wire

// *** rtl/mdp_regs.svh ***
// register map, field positions and reset values of the dma port block
`ifndef MDP_REGS_SVH
`define MDP_REGS_SVH

`define MDP_REG_CTRL 2'h0
`define MDP_REG_ADDR 2'h1
`define MDP_REG_TMO 2'h2
`define MDP_REG_LAST 2'h3
`define MDP_OFF_IRQ_STAT 8'h40
`define MDP_OFF_IRQ_MASK 8'h44
`define MDP_OFF_WDATA0 8'h48
`define MDP_OFF_WCTRL0 8'h4C
`define MDP_OFF_WDATA1 8'h50
`define MDP_OFF_WCTRL1 8'h54

`define MDP_CTRL_START 0
`define MDP_CTRL_RNW 1
`define MDP_CTRL_SIZE 3:2
`define MDP_WCTRL_BE 3:0
`define MDP_WCTRL_LANE 4
`define MDP_WCTRL_PEND 8
`define MDP_DONE_BIT 31
`define MDP_IRQ_W 12

`define MDP_BE_NONE 4'hF
`define MDP_PRESCALE_DFLT 8'h64
`define MDP_BASE_DFLT 4'h0
`define MDP_UPPER_DFLT 5'h00
`define MDP_LOW_ADDR_W 27
`define MDP_TMO_W 16

`endif

// *** rtl/mdp_pkg.sv ***
// types shared by the dma port block
package mdp_pkg;
`include "mdp_regs.svh"

   typedef enum logic [1:0]
   {
      MDP_SZ_WORD = 2'b00,
      MDP_SZ_CL4 = 2'b01,
      MDP_SZ_CL8 = 2'b10,
      MDP_SZ_BURST32 = 2'b11
   } mdp_size_t;

   typedef enum logic [2:0]
   {
      E_IDLE = 3'b000,
      E_PEND = 3'b001,
      E_ACC = 3'b011,
      E_DATA = 3'b010,
      E_DONE = 3'b110
   } mdp_eng_st_t;

   typedef struct packed
   {
      logic req;
      logic [31:0] addr;
      logic rnw;
      mdp_size_t size;
   } mdp_port_state_t;

   typedef struct packed
   {
      mdp_eng_st_t [3:0] st;
      logic [3:0] rnw;
      mdp_size_t [3:0] size;
      logic [3:0][31:0] addr;
      logic [3:0][`MDP_TMO_W-1:0] tmo;
      logic [3:0][`MDP_TMO_W-1:0] tcnt;
      logic [3:0][31:0] last;
      logic [7:0] presc;
      logic [`MDP_IRQ_W-1:0] stat;
      logic [`MDP_IRQ_W-1:0] mask;
      logic irq;
      logic [1:0][31:0] wdat;
      logic [1:0][3:0] be_rise;
      logic [1:0][3:0] be_fall;
      logic [1:0] wlane;
      logic [1:0] wpend;
      logic [1:0] push_rise;
      logic [1:0] push_fall;
      logic [1:0] launch;
      logic [1:0] owner;
      logic [1:0][31:0] laddr;
      logic [1:0] lrnw;
      mdp_size_t [1:0] lsize;
      logic ap_valid;
      logic ap_write;
      logic ap_hit;
      logic [7:0] ap_addr;
      logic hready;
      logic [31:0] hrdata;
   } mdp_top_state_t;
endpackage

// *** rtl/mdp_port_if.sv ***
// launch path from the engine arbiter to one memory port request stage
`timescale 1ns/1ps
`default_nettype none
interface mdp_port_if;
   import mdp_pkg::*;
   logic launch;
   logic [31:0] addr;
   logic rnw;
   mdp_size_t size;
   logic busy;
   modport ctl(output launch, output addr, output rnw, output size,
      input busy);
   modport req(input launch, input addr, input rnw, input size,
      output busy);
endinterface
`default_nettype wire

// *** rtl/mdp_port_req.sv ***
// address request stage of one memory port
`timescale 1ns/1ps
`default_nettype none
module mdp_port_req
   import mdp_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // launch from the arbiter
   mdp_port_if.req pif,
   // memory port address phase
   output var logic port_addr_request,
   output var logic [31:0] port_address,
   output var logic port_read_not_write,
   output var logic [1:0] port_xfer_size,
   input wire logic port_addr_accept
);
   mdp_port_state_t q;
   mdp_port_state_t n;

   always_comb
   begin
      n = q;
      if (q.req)
      begin
         // qualifiers stay frozen until the single accept pulse
         if (port_addr_accept)
         begin
            n.req = 1'b0;
         end
      end
      else if (pif.launch)
      begin
         n.req = 1'b1;
         n.addr = pif.addr;
         n.rnw = pif.rnw;
         n.size = pif.size;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q <= '0;
      end
      else
      begin
         q <= n;
      end
   end

   assign port_addr_request = q.req;
   assign port_address = q.addr;
   assign port_read_not_write = q.rnw;
   assign port_xfer_size = q.size;
   assign pif.busy = q.req;
endmodule
`default_nettype wire

// *** test/mdp_checker.sv ***
// port assertions of the dma port block
`timescale 1ns/1ps
`default_nettype none
module mdp_checker
   import mdp_pkg::*;
#(
   parameter logic [4:0] port0_addr_upper_bits = 5'h00,
   parameter logic [4:0] port1_addr_upper_bits = 5'h00
)
(
   // clock, reset and bus
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // memory port
   input wire logic [1:0] port_addr_request,
   input wire logic [1:0][31:0] port_address,
   input wire logic [1:0] port_read_not_write,
   input wire logic [1:0][1:0] port_xfer_size,
   input wire logic [1:0] port_addr_accept,
   // write lanes
   input wire logic [1:0] port_wr_push_rise,
   input wire logic [1:0] port_wr_push_fall,
   input wire logic [1:0][3:0] port_wr_byte_en_fall,
   input wire logic [1:0] port_wr_buf_full_rise,
   input wire logic [1:0] port_wr_buf_full_fall
);
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////
   sequence taken_s;
      hsel && htrans[1] && hready && hreadyout;
   endsequence
   sequence answer_s;
      !hreadyout ##1 hreadyout;
   endsequence
   // a waiting request must not move under the controller
   property hold_p(int p);
      port_addr_request[p] && !port_addr_accept[p] |=>
         port_addr_request[p] && $stable(port_address[p]) &&
         $stable(port_read_not_write[p]) && $stable(port_xfer_size[p]);
   endproperty
   property drop_p(int p);
      port_addr_request[p] && port_addr_accept[p] |=> !port_addr_request[p];
   endproperty
   ////////////////////////////////////////////////////////////////////////
   AST_ONE_WAIT: assert property (taken_s |=> answer_s)
      else $error("bus transfer not answered after one wait");
   AST_OKAY: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   AST_HOLD_P0: assert property (hold_p(0))
      else $error("port 0 request or qualifiers moved");
   AST_HOLD_P1: assert property (hold_p(1))
      else $error("port 1 request or qualifiers moved");
   AST_DROP_P0: assert property (drop_p(0))
      else $error("port 0 request kept after accept");
   AST_DROP_P1: assert property (drop_p(1))
      else $error("port 1 request kept after accept");
   AST_UPPER_P0: assert property (port_addr_request[0] |->
      port_address[0][31:27] == port0_addr_upper_bits)
      else $error("port 0 upper address bits wrong");
   AST_UPPER_P1: assert property (port_addr_request[1] |->
      port_address[1][31:27] == port1_addr_upper_bits)
      else $error("port 1 upper address bits wrong");
   AST_PUSH_RISE: assert property (port_wr_push_rise[0] |->
      !$past(port_wr_buf_full_rise[0]) ##1 !port_wr_push_rise[0])
      else $error("rise lane push while full or too long");
   AST_PUSH_FALL: assert property (port_wr_push_fall[1] |->
      !$past(port_wr_buf_full_fall[1]) ##1 !port_wr_push_fall[1])
      else $error("fall lane push while full or too long");
   AST_IDLE_LANE_BE: assert property (port_wr_push_rise[0] |->
      port_wr_byte_en_fall[0] == 4'hF)
      else $error("unused lane byte enables not all off");
endmodule
bind mdp_top mdp_checker #(
   .port0_addr_upper_bits(port0_addr_upper_bits),
   .port1_addr_upper_bits(port1_addr_upper_bits)
) u_mdp_checker (.hclk, .hresetn, .hsel, .htrans, .hready, .hreadyout,
   .hresp, .port_addr_request, .port_address, .port_read_not_write,
   .port_xfer_size, .port_addr_accept, .port_wr_push_rise,
   .port_wr_push_fall, .port_wr_byte_en_fall, .port_wr_buf_full_rise,
   .port_wr_buf_full_fall);
`default_nettype wire

// *** test/mdp_mem_model.sv ***
// memory controller port model answering both address request ports
`timescale 1ns/1ps
`default_nettype none
module mdp_mem_model
   import mdp_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // requests from the block
   input wire logic [1:0] req,
   input wire logic [1:0] rnw,
   // answer data and delay chosen by the bench
   input wire logic [1:0][31:0] word,
   input wire logic [3:0] dly,
   // answers to the block
   output logic [1:0] acc,
   output logic [1:0] rdy,
   output logic [1:0][31:0] rdat
);
   for (genvar p = 0; p < 2; p++)
   begin : g_port
      logic [3:0] cnt_q;
      logic [1:0] rd_q;
      logic acc_q;
      logic rdy_q;
      always_ff @(posedge hclk or negedge hresetn)
      begin
         if (!hresetn)
         begin
            cnt_q <= '0;
            rd_q <= '0;
            acc_q <= 1'b0;
            rdy_q <= 1'b0;
         end
         else
         begin
            // accept is a single pulse, never repeated on one request
            acc_q <= req[p] && !acc_q && cnt_q == dly;
            cnt_q <= (req[p] && !acc_q && cnt_q != dly) ? cnt_q + 4'h1 : '0;
            rdy_q <= rd_q == 2'h1;
            if (req[p] && !acc_q && cnt_q == dly && rnw[p])
               rd_q <= 2'h3;
            else if (rd_q != 2'h0)
               rd_q <= rd_q - 2'h1;
         end
      end
      assign acc[p] = acc_q;
      assign rdy[p] = rdy_q;
      // idle data shows the inverse so a stale sample cannot match
      assign rdat[p] = rdy_q ? word[p] : ~word[p];
   end
endmodule
`default_nettype wire

// *** test/mdp_top_tb.sv ***
// self-checking bench of the dma port block
`timescale 1ns/1ps
`default_nettype none
`include "mdp_regs.svh"
module mdp_top_tb;
   import mdp_pkg::*;
   localparam logic [3:0] BASE = 4'h3;
   localparam logic [4:0] UP0 = 5'h0A;
   localparam logic [4:0] UP1 = 5'h15;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = '0;
   logic [31:0] haddr = '0;
   logic [31:0] hwdata = '0;
   logic [31:0] hrdata, r, seed = 32'h0000_3aaa;
   logic hreadyout, hresp, dma_irq;
   logic [1:0] req, rnw, acc, rdy, pr, pf, fr = '0, ff = '0;
   logic [1:0][31:0] addr, rdat, wdat, word = '0;
   logic [1:0][1:0] size;
   logic [1:0][3:0] ber, bef;
   logic [3:0] dly = '0;
   int miscompares = 0;
   int n_checks = 0;
   initial forever #2 hclk = ~hclk;
   mdp_top #(.regbus_base_upper_bits(BASE), .port0_addr_upper_bits(UP0),
      .port1_addr_upper_bits(UP1), .timeout_prescale(8'h02)) DUT (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .dma_irq,
      .port_addr_request(req), .port_address(addr),
      .port_read_not_write(rnw), .port_xfer_size(size),
      .port_addr_accept(acc), .port_rd_ready(rdy), .port_rd_data(rdat),
      .port_wr_data(wdat), .port_wr_push_rise(pr), .port_wr_push_fall(pf),
      .port_wr_byte_en_rise(ber), .port_wr_byte_en_fall(bef),
      .port_wr_buf_full_rise(fr), .port_wr_buf_full_fall(ff));
   mdp_mem_model u_mem (.hclk, .hresetn, .req, .rnw, .word, .dly, .acc,
      .rdy, .rdat);
   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic hang();
      miscompares++;
      end_of_test();
   endtask
   task automatic chk(input string s, input logic [31:0] e,
      input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask
   // hready at a negedge equals its value at the next edge
   task automatic ready_wait();
      int n;
      for (n = 0; n < 100; n++)
      begin
         @(negedge hclk);
         r = hrdata;
         if (hreadyout === 1'b1)
            break;
      end
      if (hreadyout !== 1'b1)
         hang();
      @(posedge hclk);
   endtask
   task automatic bus(input logic w, input logic [31:0] a,
      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      ready_wait();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      ready_wait();
   endtask
   task automatic wr(input logic [7:0] o, input logic [31:0] d);
      bus(1'b1, {BASE, 20'h0, o}, d);
   endtask
   task automatic rd(input logic [7:0] o);
      bus(1'b0, {BASE, 20'h0, o}, '0);
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] exp_pa(input int p, input logic [31:0] a);
      return {p ? UP1 : UP0, a[26:0]};
   endfunction
   function automatic logic [31:0] exp_st(input int e, input logic rd_op,
      input logic [31:0] w);
      return (rd_op && w[31]) ? 32'h1 << (4 + e) : 32'h1 << e;
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      int e, p, n;
      logic [31:0] a, w;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      chk("ready", 1, hreadyout);
      chk("irq", 0, dma_irq);
      chk("requests", 0, {req, pr, pf});
      chk("byte enables", 32'h0000_FFFF, {ber, bef});
      $display("test reset done");
      @(posedge hclk);
      wr(`MDP_OFF_IRQ_MASK, 32'h0000_0FFF);
      for (e = 0; e < 4; e++)
      begin
         p = e / 2;
         seed = lfsr(seed);
         a = seed;
         w = lfsr(seed);
         w[31] = (e == 0);
         word[p] <= w;
         dly <= {2'b00, seed[5:4]};
         wr(8'(e * 16 + 4), a);
         wr(8'(e * 16), {28'h0, 2'(e), 1'(e != 1), 1'b1});
         for (n = 0; n < 50; n++)
         begin
            @(negedge hclk);
            if (req[p] === 1'b1)
               break;
         end
         if (req[p] !== 1'b1)
            hang();
         chk("port address", exp_pa(p, a), addr[p]);
         chk("port direction", 32'(e != 1), rnw[p]);
         chk("port size", 32'(e), size[p]);
         @(posedge hclk);
         r = '0;
         for (n = 0; n < 40 && r === 32'h0; n++)
            rd(`MDP_OFF_IRQ_STAT);
         chk("status", exp_st(e, e != 1, w), r);
         chk("irq raised", 1, dma_irq);
         if (e != 1)
            rd(8'(e * 16 + 12));
         if (e != 1)
            chk("last word", w, r);
         wr(`MDP_OFF_IRQ_STAT, exp_st(e, e != 1, w));
         rd(`MDP_OFF_IRQ_STAT);
         chk("status cleared", 0, r);
         chk("irq cleared", 0, dma_irq);
      end
      $display("test engines done");
      wr(`MDP_OFF_IRQ_MASK, 32'h0);
      wr(8'h38, 32'h0000_0008);
      // an unscaled count would already have fired by the third read
      repeat (3)
      begin
         rd(`MDP_OFF_IRQ_STAT);
         chk("early timeout", 0, r);
      end
      for (n = 0; n < 40 && r === 32'h0; n++)
         rd(`MDP_OFF_IRQ_STAT);
      chk("timeout", 32'h0000_0800, r);
      chk("masked irq", 0, dma_irq);
      wr(8'h38, 32'h0);
      wr(`MDP_OFF_IRQ_STAT, 32'h0000_0800);
      $display("test timeout done");
      bus(1'b1, {4'h5, 20'h0, `MDP_OFF_IRQ_MASK}, 32'h0000_0FFF);
      rd(`MDP_OFF_IRQ_MASK);
      chk("foreign write", 0, r);
      bus(1'b0, {4'h5, 20'h0, 8'h04}, '0);
      chk("foreign read", 0, r);
      rd(8'hFC);
      chk("unmapped read", 0, r);
      $display("test decode done");
      for (p = 0; p < 2; p++)
      begin
         seed = lfsr(seed);
         fr[0] <= (p == 0);
         ff[1] <= (p == 1);
         wr(`MDP_OFF_WDATA0 + 8'(8 * p), seed);
         wr(`MDP_OFF_WCTRL0 + 8'(8 * p), {27'h0, 1'(p), seed[3:0]});
         repeat (4) @(posedge hclk);
         rd(`MDP_OFF_WCTRL0 + 8'(8 * p));
         chk("pending", {24'h1, 3'h0, 1'(p), seed[3:0]}, r);
         fr <= '0;
         ff <= '0;
         for (n = 0; n < 20; n++)
         begin
            @(negedge hclk);
            if ((pr[p] | pf[p]) === 1'b1)
               break;
         end
         chk("push lane", p ? 2'b01 : 2'b10, {pr[p], pf[p]});
         chk("write data", seed, wdat[p]);
         chk("lane enables", {p ? 4'hF : seed[3:0], p ? seed[3:0] : 4'hF},
            {ber[p], bef[p]});
         @(posedge hclk);
         rd(`MDP_OFF_WCTRL0 + 8'(8 * p));
         chk("pending done", 0, r[8]);
      end
      $display("test lanes done");
      end_of_test();
   end
endmodule
`default_nettype wire
